// >>> rtl/eic_pkg.sv
// Constants shared by the external interrupt combiner.
`default_nettype none
package eic_pkg;
  // Location of the combined interrupt control/status bits in the I/O space.
  localparam logic [15:0] EIC_CSR_ADDR = 16'h000A;
  // Number of keyboard pins merged into the combined request.
  localparam int EIC_KBD_PINS = 4;
  // Sensitivity choices.
  localparam logic EIC_EDGE_ONLY = 1'h0;
  localparam logic EIC_EDGE_LEVEL = 1'h1;
  // Reset values.
  localparam logic EIC_FLAG_RST = 1'h0;
  localparam logic [1:0] EIC_SYNC_RST = 2'h0;
  // Idle-high pins reset their synchronisers high, so no false edge or level follows reset.
  localparam logic [1:0] EIC_HIGH_SYNC_RST = 2'h3;
  localparam logic EIC_HIGH_RST = 1'h1;
  // First address past the 32-byte I/O page.
  localparam logic [15:0] EIC_IO_END = 16'h0020;
endpackage
`default_nettype wire

// >>> rtl/eic_combiner.sv
// External interrupt combiner: request pin, keyboard pins and a falling-edge pin.
`default_nettype none
// Operation
// - Request triggers on falling edges, or falling edges plus low level, fixed at build.
// - Request pin edge is captured asynchronously, then becomes a pending interrupt.
// - With the port option on, keyboard pins are ORed into the combined request.
// - Keyboard pins act inverted: rising edge, and high level in level mode.
// - Keyboard pins follow the request pin sensitivity; no separate setting.
// - Fifth port pin is a separate falling-edge-only interrupt source.
// - Falling-edge source has its own enable and pending flag.
// - Combined interrupt control and status sit at I/O address 000A.
module eic_combiner #(
  parameter logic SENSE_MODE = eic_pkg::EIC_EDGE_ONLY,
  parameter logic KBD_ENABLE = 1'h1,
  parameter int KBD_W = eic_pkg::EIC_KBD_PINS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic irq_pin_n,
  input wire logic [KBD_W-1:0] keyboard_int_pins,
  input wire logic falling_edge_int_pin,
  input wire logic cpu_int_mask,
  input wire logic ext_int_enable,
  input wire logic ext_int_ack,
  input wire logic fe_int_enable,
  input wire logic fe_int_ack,
  output logic ext_irq_q,
  output logic ext_pend_q,
  output logic fe_irq_q,
  output logic fe_pend_q
);

  // The control and status bits must stay inside the I/O page.
  localparam logic [15:0] CSR_ADDR = eic_pkg::EIC_CSR_ADDR;

  // Four keyboard pins feed the combined request; other widths have no pins to serve.
  if (KBD_W != eic_pkg::EIC_KBD_PINS) begin : g_bad_kbd_w
    $error("eic_combiner: KBD_W must equal the keyboard pin count");
  end
  if (CSR_ADDR >= eic_pkg::EIC_IO_END) begin : g_bad_csr
    $error("eic_combiner: control address lies outside the I/O page");
  end

  logic cap_q;
  logic cap_clr_q;
  logic cap_rst_n;
  logic [1:0] cap_sync_q;
  logic cap_seen_q;
  logic [1:0] pin_sync_q;
  logic [KBD_W-1:0] kbd_s1_q;
  logic [KBD_W-1:0] kbd_s2_q;
  logic [KBD_W-1:0] kbd_prev_q;
  logic [1:0] fe_sync_q;
  logic fe_prev_q;
  logic cap_event;
  logic kbd_event;
  logic level_active;
  logic fe_event;

  // One new-edge test serves the capture and falling-edge inputs; the keyboard pins use their own inline test.
  function automatic logic new_edge(input logic now, input logic was);
    return now & ~was;
  endfunction

  // The capture flop is cleared by reset or once the clocked side has seen it.
  assign cap_rst_n = reset_n & ~cap_clr_q;

  // An edge is caught even when no clock samples the pin at that moment.
  always_ff @(negedge irq_pin_n or negedge cap_rst_n) begin
    if (!cap_rst_n) begin
      cap_q <= eic_pkg::EIC_FLAG_RST;
    end else begin
      cap_q <= 1'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_sync_q <= eic_pkg::EIC_SYNC_RST;
      cap_seen_q <= eic_pkg::EIC_FLAG_RST;
      cap_clr_q <= eic_pkg::EIC_FLAG_RST;
    end else begin
      cap_sync_q <= {cap_sync_q[0], cap_q};
      cap_seen_q <= cap_sync_q[1];
      cap_clr_q <= cap_sync_q[1];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_q <= eic_pkg::EIC_HIGH_SYNC_RST;
      kbd_s1_q <= '0;
      kbd_s2_q <= '0;
      kbd_prev_q <= '0;
      fe_sync_q <= eic_pkg::EIC_HIGH_SYNC_RST;
      fe_prev_q <= eic_pkg::EIC_HIGH_RST;
    end else begin
      pin_sync_q <= {pin_sync_q[0], irq_pin_n};
      kbd_s1_q <= keyboard_int_pins;
      kbd_s2_q <= kbd_s1_q;
      kbd_prev_q <= kbd_s2_q;
      fe_sync_q <= {fe_sync_q[0], falling_edge_int_pin};
      fe_prev_q <= fe_sync_q[1];
    end
  end

  assign cap_event = new_edge(cap_sync_q[1], cap_seen_q);
  // Keyboard pins share the request pin's sense choice but with inverted phase.
  assign kbd_event = KBD_ENABLE & (|(kbd_s2_q & ~kbd_prev_q));
  // Level sensing uses synchronised copies, so a level shorter than one clock may be missed.
  assign level_active = (SENSE_MODE == eic_pkg::EIC_EDGE_LEVEL) &
    (~pin_sync_q[1] | (KBD_ENABLE & (|kbd_s2_q)));
  // A fall is a rise of the inverted copies.
  assign fe_event = new_edge(~fe_sync_q[1], ~fe_prev_q);

  // A new edge in the acknowledge cycle wins, so no request is lost.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_pend_q <= eic_pkg::EIC_FLAG_RST;
    end else if (cap_event || kbd_event) begin
      ext_pend_q <= 1'h1;
    end else if (ext_int_ack) begin
      ext_pend_q <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_irq_q <= eic_pkg::EIC_FLAG_RST;
    end else begin
      ext_irq_q <= (ext_pend_q | level_active) & ext_int_enable & ~cpu_int_mask;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fe_pend_q <= eic_pkg::EIC_FLAG_RST;
    end else if (fe_event) begin
      fe_pend_q <= 1'h1;
    end else if (fe_int_ack) begin
      fe_pend_q <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fe_irq_q <= eic_pkg::EIC_FLAG_RST;
    end else begin
      fe_irq_q <= fe_pend_q & fe_int_enable & ~cpu_int_mask;
    end
  end

  pin_edge_pend_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(irq_pin_n) ##1 (!ext_int_ack) [*4] |-> ##1 ext_pend_q)
    else $error("request pin edge not pending");
  kbd_rise_pend_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    KBD_ENABLE && (|(keyboard_int_pins & ~$past(keyboard_int_pins))) ##1 (!ext_int_ack) [*3] |=> ext_pend_q)
    else $error("keyboard rise not pending");
  kbd_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !KBD_ENABLE |-> !kbd_event)
    else $error("keyboard contributes while disabled");
  pend_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ext_pend_q && !ext_int_ack |=> ext_pend_q)
    else $error("pending lost without acknowledge");
  mask_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(cpu_int_mask) |-> !ext_irq_q && !fe_irq_q)
    else $error("request passed CPU mask");
  level_req_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    SENSE_MODE == eic_pkg::EIC_EDGE_LEVEL && !pin_sync_q[1] && ext_int_enable && !cpu_int_mask
    |=> ext_irq_q)
    else $error("low level gave no request");
  edge_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    SENSE_MODE == eic_pkg::EIC_EDGE_ONLY |-> !level_active)
    else $error("level sensing in edge mode");
  fe_fall_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(falling_edge_int_pin) ##1 !fe_int_ack [*3] |=> fe_pend_q)
    else $error("falling edge not pending");
  fe_rise_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fe_pend_q && !fe_event |=> !fe_pend_q)
    else $error("falling-edge flag set without a fall");
  fe_own_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fe_irq_q |-> $past(fe_pend_q) && $past(fe_int_enable))
    else $error("falling-edge request without own flag and enable");

  // Acknowledge of both pending flags; race and quiet handling of the combined flag.
  ext_ack_clr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ext_pend_q && ext_int_ack && !cap_event && !kbd_event |=> !ext_pend_q)
    else $error("acknowledge did not clear pending");
  ack_race_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ext_int_ack && (cap_event || kbd_event) |=> ext_pend_q)
    else $error("edge lost in acknowledge cycle");
  fe_ack_clr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fe_pend_q && fe_int_ack && !fe_event |=> !fe_pend_q)
    else $error("acknowledge did not clear falling-edge flag");
  ext_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ext_pend_q && !cap_event && !kbd_event |=> !ext_pend_q)
    else $error("combined flag set without its own source");

  // Request outputs against their sources.
  kbd_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    SENSE_MODE == eic_pkg::EIC_EDGE_LEVEL && KBD_ENABLE && (|kbd_s2_q) && ext_int_enable && !cpu_int_mask
    |=> ext_irq_q)
    else $error("keyboard high level gave no request");
  irq_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ext_pend_q && !level_active |=> !ext_irq_q)
    else $error("request without pending or level");
  fe_irq_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fe_pend_q && fe_int_enable && !cpu_int_mask |=> fe_irq_q)
    else $error("falling-edge flag gave no request");
  fe_irq_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fe_pend_q |=> !fe_irq_q)
    else $error("falling-edge request without flag");

  // Main scenarios worth seeing at least once.
  ext_req_c: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(ext_irq_q));
  lvl_req_c: cover property (@(posedge ref_clk) disable iff (!reset_n) level_active && ext_irq_q);
  kbd_pend_c: cover property (@(posedge ref_clk) disable iff (!reset_n) kbd_event);
  fe_req_c: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(fe_irq_q));
  ack_race_c: cover property (@(posedge ref_clk) disable iff (!reset_n) ext_int_ack && (cap_event || kbd_event));

endmodule
`default_nettype wire

// >>> bench/eic_keys.sv
// Model of the keys and devices that drive the interrupt pins.
`default_nettype none
module eic_keys (
  input wire logic [5:0] want,
  output logic irq_pin_n,
  output logic [3:0] keyboard_int_pins,
  output logic falling_edge_int_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins are never released, so every level is always defined.
  assign {irq_pin_n, keyboard_int_pins, falling_edge_int_pin} = want;
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the external interrupt combiner.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [5:0] want = 6'h21;
  logic mask = 1'h0, en = 1'h0, ack = 1'h0, fe_ack = 1'h0;
  logic irq_n, fe_pin, ei, ep, fi, fp, li, lp, op;
  logic [3:0] kbd;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  eic_keys keys (.want(want), .irq_pin_n(irq_n), .keyboard_int_pins(kbd), .falling_edge_int_pin(fe_pin));
  eic_combiner dut (.ref_clk(ref_clk), .reset_n(reset_n), .irq_pin_n(irq_n), .keyboard_int_pins(kbd),
    .falling_edge_int_pin(fe_pin), .cpu_int_mask(mask), .ext_int_enable(en), .ext_int_ack(ack),
    .fe_int_enable(en), .fe_int_ack(fe_ack), .ext_irq_q(ei), .ext_pend_q(ep), .fe_irq_q(fi), .fe_pend_q(fp));
  eic_combiner #(.SENSE_MODE(eic_pkg::EIC_EDGE_LEVEL)) lvl (.ref_clk(ref_clk), .reset_n(reset_n),
    .irq_pin_n(irq_n), .keyboard_int_pins(kbd), .falling_edge_int_pin(fe_pin), .cpu_int_mask(mask),
    .ext_int_enable(en), .ext_int_ack(ack), .fe_int_enable(en), .fe_int_ack(fe_ack), .ext_irq_q(li),
    .ext_pend_q(lp), .fe_irq_q(), .fe_pend_q());
  eic_combiner #(.KBD_ENABLE(1'h0)) off (.ref_clk(ref_clk), .reset_n(reset_n), .irq_pin_n(irq_n),
    .keyboard_int_pins(kbd), .falling_edge_int_pin(fe_pin), .cpu_int_mask(mask), .ext_int_enable(en),
    .ext_int_ack(ack), .fe_int_enable(en), .fe_int_ack(fe_ack), .ext_irq_q(), .ext_pend_q(op),
    .fe_irq_q(), .fe_pend_q());
  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Pin i is held active across the acknowledge, so level mode must keep asking for pins 1 to 5 (not the falling-edge pin 0).
  task automatic run(input int i, input logic e, input logic m);
    logic x;
    x = e & ~m;
    en = e;
    mask = m;
    want[i] = ~want[i];
    repeat (6) @(negedge ref_clk);
    if (i == 0) begin
      chk("fe_pend", 1'h1, fp);
      chk("fe_irq", x, fi);
      fe_ack = 1'h1;
    end else begin
      chk("ext_pend", 1'h1, ep);
      chk("ext_irq", x, ei);
      chk("lvl_pend", 1'h1, lp);
      chk("off_pend", 1'(i == 5), op);
      ack = 1'h1;
    end
    @(negedge ref_clk);
    ack = 1'h0;
    fe_ack = 1'h0;
    repeat (4) @(negedge ref_clk);
    chk("cleared", 1'h0, ep | fp | ei | fi);
    chk("lvl_hold", x && i > 0, li);
    want[i] = ~want[i];
    repeat (4) @(negedge ref_clk);
    chk("lvl_drop", 1'h0, li);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(16762));
    repeat (6) @(negedge ref_clk);
    chk("reset", 1'h0, ei | ep | fi | fp);
    reset_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      run(i, 1'h1, 1'h0);
    end
    repeat (20) begin
      run(int'($urandom_range(5, 0)), 1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
